// ===== core/flash_sector_access_control.v
// Behaviour
// - The array is erased whole or by one sector, and programmed one byte at a time.
// - Work on one sector never changes the contents of another sector.
// - A 4K array has sector 0, an 8K array sectors 0 and 1, larger arrays sectors 0 to 2.
// - Sectors 0 and 1 are 4K at the top, sector 0 at F000h-FFFFh holding the vectors.
// - In-application mode may program or erase any sector except sector 0.
// - Tool-insertion and in-circuit modes may program or erase every sector and option bytes.
// - With read-out protection on, no external read of program memory is allowed.
// - One option bit sets and clears protection, and clearing it first erases the whole array.
// - The link is one serial clock, one two-way data pin and a mode-select pin.
// - With the tool attached the clock and data pins are denied to the application.
// - An 8-bit control and status register, reset to 00h, governs program and erase.
`timescale 1ns/1ps
`include "flash_access_map.vh"
`default_nettype none

module flash_sector_access_control
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Configuration
    input wire [1:0] arraySize,
    input wire toolInserted,
    // Application side requests
    input wire appReq,
    input wire [1:0] appOp,
    input wire [15:0] appAddr,
    input wire [7:0] appData,
    input wire appPinOut,
    input wire appPinOe,
    // Tool side requests
    input wire toolReq,
    input wire [1:0] toolOp,
    input wire [15:0] toolAddr,
    input wire [7:0] toolData,
    input wire toolReadReq,
    input wire optWrite,
    input wire optProtect,
    // Programming link pins
    input wire prog_link_clock,
    input wire prog_link_data_in,
    output reg prog_link_data_out,
    output reg prog_link_data_oe,
    input wire prog_mode_select,
    // Flash array command port
    output reg arrayStart,
    output reg [1:0] arrayOp,
    output reg [15:0] arrayAddr,
    output reg [7:0] arrayData,
    input wire arrayDone,
    // Status
    output reg [7:0] flash_ctrl_status,
    output reg readout_protect_option_bit,
    output reg [1:0] progMode,
    output reg toolReadAllow,
    output reg appPinsBlocked,
    output reg appLinkClock,
    output reg appLinkData,
    output reg reqDenied
);

// ============================================================
// Pin synchronisers
wire syncClk;
wire syncData;
wire syncSel;

pin_sync clkSync (.mclk(mclk), .reset_n(reset_n), .pinIn(prog_link_clock), .pinOut(syncClk));
pin_sync dataSync (.mclk(mclk), .reset_n(reset_n), .pinIn(prog_link_data_in),
    .pinOut(syncData));
pin_sync selSync (.mclk(mclk), .reset_n(reset_n), .pinIn(prog_mode_select), .pinOut(syncSel));

// ============================================================
// Mode tracking
reg syncClkDly;
reg icMode;
wire linkClockRise;

assign linkClockRise = syncClk & ~syncClkDly;

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        syncClkDly <= 1'b0;
        icMode <= 1'b0;
    end
    else
    begin
        syncClkDly <= syncClk;
        // Tool raises mode select, then the first link clock rise enters the in-circuit session
        if (!syncSel)
            icMode <= 1'b0;
        else if (linkClockRise)
            icMode <= 1'b1;
    end
end

// ============================================================
// Sector decode
// Base addresses of the two fixed sectors
localparam [15:0] SECTOR0_ADDR = `SECTOR0_BASE;
localparam [15:0] SECTOR1_ADDR = `SECTOR1_BASE;

function [1:0] sectorOf;
    input [15:0] addr;
    input [1:0] size;
    reg [3:0] page;
    begin
        page = addr[15:`SECTOR_SHIFT];
        if (page == SECTOR0_ADDR[15:`SECTOR_SHIFT])
            sectorOf = `SECT_0;
        else if (page == SECTOR1_ADDR[15:`SECTOR_SHIFT])
            sectorOf = (size == `SIZE_4K) ? `SECT_NONE : `SECT_1;
        else
            sectorOf = (size == `SIZE_4K || size == `SIZE_8K) ? `SECT_NONE : `SECT_2;
    end
endfunction

function addrInArray;
    input [15:0] addr;
    input [1:0] size;
    reg [4:0] pages;
    begin
        case (size)
            `SIZE_4K: pages = 5'h01;
            `SIZE_8K: pages = 5'h02;
            `SIZE_16K: pages = 5'h04;
            default: pages = 5'h08;
        endcase
        addrInArray = ({1'b0, ~addr[15:`SECTOR_SHIFT]} < pages);
    end
endfunction

// ============================================================
// Request arbitration and protection
reg [1:0] next_mode;
reg useTool;
reg [1:0] reqOp;
reg [15:0] reqAddr;
reg [7:0] reqData;
reg allow;
reg [1:0] reqSector;

always @*
begin
    if (toolInserted)
        next_mode = `MODE_TOOL;
    else if (icMode)
        next_mode = `MODE_ICP;
    else
        next_mode = `MODE_IAP;
    useTool = (next_mode != `MODE_IAP) && toolReq;
    reqOp = useTool ? toolOp : appOp;
    reqAddr = useTool ? toolAddr : appAddr;
    reqData = useTool ? toolData : appData;
    reqSector = sectorOf(reqAddr, arraySize);
    allow = 1'b0;
    if (useTool || (next_mode == `MODE_IAP && appReq))
    begin
        if (reqOp == `OP_ERASE_ALL)
            allow = useTool;
        else if (reqOp == `OP_NONE)
            allow = 1'b0;
        else if (!addrInArray(reqAddr, arraySize) || reqSector == `SECT_NONE)
            allow = 1'b0;
        else if (useTool)
            allow = 1'b1;
        else
            allow = (reqSector != `SECT_0);
    end
end

// ============================================================
// Operation sequencer
localparam ST_IDLE = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_MASS = 2'h2;

reg [1:0] state;
reg [`CNT_W-1:0] opCount;
reg pendUnprotect;

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        state <= ST_IDLE;
        opCount <= {`CNT_W{1'b0}};
        arrayStart <= 1'b0;
        arrayOp <= `OP_NONE;
        arrayAddr <= 16'h0000;
        arrayData <= 8'h00;
        flash_ctrl_status <= `CTRL_RESET;
        readout_protect_option_bit <= 1'b0;
        pendUnprotect <= 1'b0;
        reqDenied <= 1'b0;
        progMode <= `MODE_NONE;
    end
    else
    begin
        arrayStart <= 1'b0;
        reqDenied <= 1'b0;
        progMode <= next_mode;
        flash_ctrl_status[`CTRL_PROTECT] <= readout_protect_option_bit;
        case (state)
            ST_IDLE:
            begin
                flash_ctrl_status[`CTRL_BUSY] <= 1'b0;
                if (optWrite && next_mode != `MODE_IAP)
                begin
                    if (readout_protect_option_bit && !optProtect)
                    begin
                        // Whole array goes first, then the bit clears
                        arrayStart <= 1'b1;
                        arrayOp <= `OP_ERASE_ALL;
                        pendUnprotect <= 1'b1;
                        flash_ctrl_status[`CTRL_MASS] <= 1'b1;
                        flash_ctrl_status[`CTRL_BUSY] <= 1'b1;
                        opCount <= `OP_CYCLES;
                        state <= ST_MASS;
                    end
                    else
                        readout_protect_option_bit <= optProtect;
                end
                else if (allow)
                begin
                    arrayStart <= 1'b1;
                    arrayOp <= reqOp;
                    arrayAddr <= reqAddr;
                    arrayData <= reqData;
                    flash_ctrl_status[`CTRL_BUSY] <= 1'b1;
                    flash_ctrl_status[`CTRL_MASS] <= (reqOp == `OP_ERASE_ALL);
                    flash_ctrl_status[`CTRL_DENIED] <= 1'b0;
                    opCount <= `OP_CYCLES;
                    state <= ST_RUN;
                end
                else if ((useTool || (next_mode == `MODE_IAP && appReq)) && reqOp != `OP_NONE)
                begin
                    reqDenied <= 1'b1;
                    flash_ctrl_status[`CTRL_DENIED] <= 1'b1;
                end
            end
            ST_RUN, ST_MASS:
            begin
                if (opCount != {`CNT_W{1'b0}})
                    opCount <= opCount - {{(`CNT_W-1){1'b0}}, 1'b1};
                if (arrayDone && opCount == {`CNT_W{1'b0}})
                begin
                    if (state == ST_MASS && pendUnprotect)
                        readout_protect_option_bit <= 1'b0;
                    pendUnprotect <= 1'b0;
                    flash_ctrl_status[`CTRL_BUSY] <= 1'b0;
                    state <= ST_IDLE;
                end
            end
            default:
                state <= ST_IDLE;
        endcase
    end
end

// ============================================================
// Pin ownership and read gating
always @(posedge mclk)
begin
    if (!reset_n)
    begin
        toolReadAllow <= 1'b0;
        appPinsBlocked <= 1'b0;
        appLinkClock <= 1'b0;
        appLinkData <= 1'b0;
        prog_link_data_out <= 1'b0;
        prog_link_data_oe <= 1'b0;
    end
    else
    begin
        toolReadAllow <= toolReadReq && !readout_protect_option_bit;
        appPinsBlocked <= syncSel || toolInserted;
        if (syncSel || toolInserted)
        begin
            appLinkClock <= 1'b0;
            appLinkData <= 1'b0;
            prog_link_data_out <= 1'b0;
            prog_link_data_oe <= 1'b0;
        end
        else
        begin
            appLinkClock <= syncClk;
            appLinkData <= syncData;
            prog_link_data_out <= appPinOut;
            prog_link_data_oe <= appPinOe;
        end
    end
end

endmodule

`default_nettype wire

// ===== core/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Pin in, synchronous out
    input wire pinIn,
    output reg pinOut
);

reg stage1;

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        stage1 <= 1'b0;
        pinOut <= 1'b0;
    end
    else
    begin
        stage1 <= pinIn;
        pinOut <= stage1;
    end
end

endmodule

`default_nettype wire

// ===== shared/flash_access_map.vh
`ifndef FLASH_ACCESS_MAP_VH
`define FLASH_ACCESS_MAP_VH

// ============================================================
// Array geometry
`define ADDR_W 16
`define SECTOR0_BASE 16'hF000
`define SECTOR1_BASE 16'hE000
`define SECTOR_SHIFT 12
`define SIZE_4K 2'h0
`define SIZE_8K 2'h1
`define SIZE_16K 2'h2
`define SIZE_32K 2'h3
`define SECT_NONE 2'h3
`define SECT_0 2'h0
`define SECT_1 2'h1
`define SECT_2 2'h2

// ============================================================
// Operation codes
`define OP_NONE 2'h0
`define OP_PROG 2'h1
`define OP_ERASE_SECT 2'h2
`define OP_ERASE_ALL 2'h3

// ============================================================
// Programming modes
`define MODE_TOOL 2'h0
`define MODE_ICP 2'h1
`define MODE_IAP 2'h2
`define MODE_NONE 2'h3

// ============================================================
// Control/status register
`define CTRL_RESET 8'h00
`define CTRL_BUSY 0
`define CTRL_DENIED 1
`define CTRL_MASS 2
`define CTRL_PROTECT 3

// ============================================================
// Array operation timing
`define OP_TIME_NS 100
`define CLK_PERIOD_NS 5
// Cycles per operation, 100 ns at a 5 ns clock
`define OP_CYCLES 8'h14
`define CNT_W 8
`define SAMPLE_W 2

`endif

// ===== test/flash_access_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Access checks
module flash_access_asserts
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Requests
    input wire logic [1:0] arraySize,
    input wire logic toolInserted,
    input wire logic appReq,
    input wire logic [1:0] appOp,
    input wire logic [15:0] appAddr,
    input wire logic toolReadReq,
    input wire logic optWrite,
    input wire logic optProtect,
    // Results
    input wire logic arrayStart,
    input wire logic [1:0] arrayOp,
    input wire logic [15:0] arrayAddr,
    input wire logic [7:0] flash_ctrl_status,
    input wire logic readout_protect_option_bit,
    input wire logic [1:0] progMode,
    input wire logic toolReadAllow,
    input wire logic appPinsBlocked,
    input wire logic appLinkClock,
    input wire logic appLinkData,
    input wire logic reqDenied
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
sequence appVector;
    appReq && !flash_ctrl_status[0] && progMode == 2'h2 && appAddr[15:12] == 4'hF;
endsequence
sequence startPulse;
    arrayStart ##1 !arrayStart;
endsequence
chk_vector_deny: assert property (appVector ##0 appOp != 2'h0 |=> reqDenied)
    else $error("vector sector request not refused");
chk_iap_guard: assert property (arrayStart && progMode == 2'h2 |->
    arrayAddr[15:12] != 4'hF && arrayOp != 2'h3) else $error("vector sector touched");
chk_start_once: assert property (arrayStart |-> startPulse)
    else $error("start longer than one cycle");
chk_busy_hold: assert property (arrayStart |-> flash_ctrl_status[0] [*8])
    else $error("busy dropped early");
chk_read_gate: assert property (toolReadAllow |->
    $past(toolReadReq) && !$past(readout_protect_option_bit)) else $error("read not gated");
chk_pins_hidden: assert property (appPinsBlocked |-> !appLinkClock && !appLinkData)
    else $error("link pins leak");
chk_tool_blocks: assert property (toolInserted [*3] |-> appPinsBlocked)
    else $error("pins not blocked");
chk_unprotect_erase: assert property (optWrite && !optProtect &&
    readout_protect_option_bit && progMode != 2'h2 && !flash_ctrl_status[0]
    |=> arrayStart && arrayOp == 2'h3) else $error("no mass erase");
chk_size_map: assert property (arrayStart && arrayOp != 2'h3 |-> arraySize > 2'h1 ||
    arrayAddr[15:12] == 4'hF || (arraySize == 2'h1 && arrayAddr[15:12] == 4'hE))
    else $error("sector outside array");
chk_reset_status: assert property ($rose(reset_n) |-> flash_ctrl_status == 8'h00)
    else $error("status not cleared");
endmodule
`default_nettype wire

// ===== test/prog_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Programming tool
module prog_tool_model
(
    // Session control
    input wire logic session,
    // Link pins
    output logic prog_link_clock,
    output logic prog_mode_select,
    output logic prog_link_data_in
);
initial
begin
    prog_link_clock = 1'b0;
    prog_mode_select = 1'b0;
    prog_link_data_in = 1'b0;
end
always @(posedge session)
begin
    prog_mode_select = 1'b1;
    while (session)
    begin
        #62.5 prog_link_clock = 1'b1;
        prog_link_data_in = ~prog_link_data_in;
        #62.5 prog_link_clock = 1'b0;
    end
    prog_mode_select = 1'b0;
end
always @(negedge prog_mode_select)
    prog_link_data_in = ~prog_link_data_in;
endmodule
`default_nettype wire

// ===== test/test_flash_sector_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_sector_access_control;
logic mclk = 0, reset_n = 0, toolInserted = 0, appReq = 0, toolReq = 0, toolReadReq = 0;
logic optWrite = 0, optProtect = 0, arrayDone = 0, session = 0, quiet = 0;
logic appPinOut = 0, appPinOe = 0;
logic [1:0] arraySize = 2'h3, appOp = 2'h0, toolOp = 2'h0;
logic [15:0] appAddr = 16'h0000, toolAddr = 16'h0000;
logic [7:0] appData = 8'h00, toolData = 8'h5A;
wire prog_link_clock, prog_mode_select, prog_link_data_in, prog_link_data_out;
wire prog_link_data_oe, arrayStart, readout_protect_option_bit, toolReadAllow;
wire appPinsBlocked, appLinkClock, appLinkData, reqDenied;
wire [1:0] arrayOp, progMode;
wire [15:0] arrayAddr;
wire [7:0] arrayData, flash_ctrl_status;
int miscompares = 0, num_checks = 0, seed = 58, dly = 0;
logic [18:0] expq[$];
logic [7:0] dataq[$];
flash_sector_access_control flash_sector_access_control_inst (.mclk(mclk), .reset_n(reset_n),
    .arraySize(arraySize), .toolInserted(toolInserted), .appReq(appReq), .appOp(appOp),
    .appAddr(appAddr), .appData(appData), .appPinOut(appPinOut), .appPinOe(appPinOe),
    .toolReq(toolReq), .toolOp(toolOp), .toolAddr(toolAddr), .toolData(toolData),
    .toolReadReq(toolReadReq), .optWrite(optWrite), .optProtect(optProtect),
    .prog_link_clock(prog_link_clock), .prog_link_data_in(prog_link_data_in),
    .prog_link_data_out(prog_link_data_out), .prog_link_data_oe(prog_link_data_oe),
    .prog_mode_select(prog_mode_select), .arrayStart(arrayStart), .arrayOp(arrayOp),
    .arrayAddr(arrayAddr), .arrayData(arrayData), .arrayDone(arrayDone),
    .flash_ctrl_status(flash_ctrl_status),
    .readout_protect_option_bit(readout_protect_option_bit), .progMode(progMode),
    .toolReadAllow(toolReadAllow), .appPinsBlocked(appPinsBlocked),
    .appLinkClock(appLinkClock), .appLinkData(appLinkData), .reqDenied(reqDenied));
prog_tool_model prog_tool_model_inst (.session(session), .prog_link_clock(prog_link_clock),
    .prog_mode_select(prog_mode_select), .prog_link_data_in(prog_link_data_in));
always #2.5 mclk = ~mclk;
// ========
// Array and checks
always @(posedge mclk)
begin
    if (arrayStart)
        dly <= 20 + ($unsigned($random(seed)) % 8);
    else if (dly > 0)
        dly <= dly - 1;
    arrayDone <= (dly == 1) || (arrayDone && flash_ctrl_status[0]);
end
task automatic check(string nm, logic [18:0] e, logic [18:0] s);
    num_checks++;
    if (s !== e)
    begin
        miscompares++;
        $display("unexpected %s expected %h seen %h", nm, e, s);
    end
endtask
task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
always @(negedge mclk)
    if ((arrayStart || reqDenied) && !quiet)
        check("array command", expq.size() ? expq.pop_front() : 19'h7FFFF,
            arrayStart ? {1'b1, arrayOp, arrayOp == 2'h3 ? 16'h0000 : arrayAddr} : 19'h0);
always @(negedge mclk)
    if (arrayStart && arrayOp == 2'h1 && !quiet)
        check("array data", {11'h0, dataq.size() ? dataq.pop_front() : 8'hFF},
            {11'h0, arrayData});
task waitIdle;
    int n;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    for (n = 0; n < 300 && flash_ctrl_status[0] !== 1'b0; n++)
        @(negedge mclk);
    if (n == 300)
    begin
        miscompares++;
        report_and_stop;
    end
    @(posedge mclk);
endtask
task automatic req(logic tool, logic [1:0] op, logic [15:0] a, logic ok);
    logic [7:0] d;
    d = $random(seed);
    @(posedge mclk);
    if (tool)
    begin
        toolReq <= 1'b1;
        toolOp <= op;
        toolAddr <= a;
    end
    else
    begin
        appReq <= 1'b1;
        appOp <= op;
        appAddr <= a;
        appData <= d;
    end
    expq.push_back(ok ? {1'b1, op, op == 2'h3 ? 16'h0000 : a} : 19'h0);
    if (ok && op == 2'h1)
        dataq.push_back(tool ? toolData : d);
    @(posedge mclk);
    toolReq <= 1'b0;
    appReq <= 1'b0;
    waitIdle;
endtask
task automatic option(logic p);
    @(posedge mclk);
    optWrite <= 1'b1;
    optProtect <= p;
    @(posedge mclk);
    optWrite <= 1'b0;
    waitIdle;
endtask
task automatic readChk(logic e);
    @(posedge mclk);
    toolReadReq <= 1'b1;
    @(posedge mclk);
    toolReadReq <= 1'b0;
    @(negedge mclk);
    check("read allow", {18'h0, e}, {18'h0, toolReadAllow});
endtask
// ========
// Main sequence
initial
begin
    int n;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int s = 0; s < 4; s++)
    begin
        arraySize <= s[1:0];
        req(0, 2'h1, 16'hE000 | ($random(seed) & 16'h0FFF), s != 0);
        req(0, 2'h2, 16'hF000, 0);
        req(0, 2'h2, 16'hC000, s > 1);
        req(0, 2'h3, 16'h0000, 0);
    end
    appPinOut <= 1'b1;
    appPinOe <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("pin drive", 19'h3, {17'h0, prog_link_data_oe, prog_link_data_out});
    $display("in-application sector map done");
    @(posedge mclk);
    toolInserted <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("pins blocked", 19'h4,
        {16'h0, appPinsBlocked, prog_link_data_oe, prog_link_data_out});
    req(1, 2'h2, 16'hF000, 1);
    req(1, 2'h3, 16'h0000, 1);
    quiet <= 1'b1;
    option(1);
    quiet <= 1'b0;
    check("protect bit", 19'h1, {18'h0, readout_protect_option_bit});
    readChk(0);
    expq.push_back({1'b1, 2'h3, 16'h0000});
    option(0);
    check("protect bit", 19'h0, {18'h0, readout_protect_option_bit});
    readChk(1);
    $display("tool and protection done");
    @(posedge mclk);
    toolInserted <= 1'b0;
    session <= 1'b1;
    for (n = 0; n < 400 && progMode !== 2'h1; n++)
        @(negedge mclk);
    check("link mode", 19'h1, {17'h0, progMode});
    if (n == 400)
        report_and_stop;
    req(1, 2'h2, 16'hF000, 1);
    session <= 1'b0;
    repeat (60) @(posedge mclk);
    @(negedge mclk);
    check("pins released", {18'h0, prog_link_data_in},
        {17'h0, appPinsBlocked, appLinkData});
    check("queue drained", 19'h0, expq.size() + dataq.size());
    $display("in-circuit done");
    report_and_stop;
end
endmodule
bind flash_sector_access_control flash_access_asserts chk_inst (.mclk(mclk),
    .reset_n(reset_n), .arraySize(arraySize), .toolInserted(toolInserted),
    .appReq(appReq), .appOp(appOp), .appAddr(appAddr), .toolReadReq(toolReadReq),
    .optWrite(optWrite), .optProtect(optProtect), .arrayStart(arrayStart),
    .arrayOp(arrayOp), .arrayAddr(arrayAddr), .flash_ctrl_status(flash_ctrl_status),
    .readout_protect_option_bit(readout_protect_option_bit), .progMode(progMode),
    .toolReadAllow(toolReadAllow), .appPinsBlocked(appPinsBlocked),
    .appLinkClock(appLinkClock), .appLinkData(appLinkData), .reqDenied(reqDenied));
`default_nettype wire
